// ===== shared/stack_pkg.sv
// Constants for the stack pointer unit: register layout, reset values, commands.
// Assumes a single core clock domain; used by the offset counter and the unit top, not by the byte RAM.
package stack_pkg;
  // ==========================================================
  // Register map of the plain register port
  localparam logic [1:0] ADDR_POINTER_LOW = 2'h0;
  localparam logic [1:0] ADDR_POINTER_HIGH = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_COND_CODE = 2'h3;
  // ==========================================================
  // Pointer layout and reset values
  localparam int PTR_WIDTH = 16;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] STACK_TOP = 8'hff;
  localparam logic [15:0] POINTER_RESET = 16'h01ff;
  localparam logic [7:0] COND_CODE_RESET = 8'h28;
  localparam int PRIO_LOW_POS = 3;
  localparam int PRIO_HIGH_POS = 5;
  // ==========================================================
  // Frame lengths in bytes
  localparam logic [2:0] CALL_BYTES = 3'h2;
  localparam logic [2:0] INT_BYTES = 3'h5;
  // ==========================================================
  // Sequencer commands
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_PUSH = 3'h1,
    CMD_POP = 3'h2,
    CMD_CALL = 3'h3,
    CMD_RET = 3'h4,
    CMD_INT = 3'h5,
    CMD_IRET = 3'h6,
    CMD_RESET_STACK = 3'h7
  } cmd_t;
  // Frame sequencer states, Gray along the push path only
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSHING = 2'b01,
    ST_POPPING = 2'b11
  } frame_state_t;
endpackage : stack_pkg

// ===== rtl/stack_offset_counter.sv
// Low byte of the stack pointer with push, pop, load and reset.
// Assumes at most one operation per cycle from the frame sequencer.
`timescale 1ns/1ps
`default_nettype none
module stack_offset_counter (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dec,
  input wire logic inc,
  input wire logic load,
  input wire logic [7:0] load_value,
  input wire logic reset_stack,
  output logic [7:0] stack_offset_bits
);
  logic [7:0] next_offset;

  always_comb begin
    next_offset = stack_offset_bits;
    if (reset_stack) begin
      next_offset = stack_pkg::STACK_TOP;
    end else if (load) begin
      next_offset = load_value;
    end else if (dec) begin
      // Wraps silently below the page bottom
      next_offset = stack_offset_bits - 8'h01;
    end else if (inc) begin
      next_offset = stack_offset_bits + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stack_offset_bits <= stack_pkg::STACK_TOP;
    end else begin
      stack_offset_bits <= next_offset;
    end
  end
endmodule : stack_offset_counter
`default_nettype wire

// ===== rtl/stack_byte_ram.sv
// Byte storage for the 256-byte stack page, flip-flops addressed by offset.
// Assumes one write or one read per cycle; reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module stack_byte_ram #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  assign rdata = mem[addr];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_cell
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mem[i] <= 8'h00;
        end else if (we && (addr == 8'(i))) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate
endmodule : stack_byte_ram
`default_nettype wire

// ===== rtl/cpu_stack_pointer_unit.sv
// Stack pointer unit of an 8-bit core: pointer, stack page, frame sequencing.
// Assumes the sequencer issues one command at a time and waits while busy.
//
// Function
// - Pointer is 16 bits, addresses next free
// - Decrement after push, increment before pop
// - 256-byte stack, upper byte fixed
// - Reset and stack-reset instruction give 01FF
// - Low byte loadable and readable
// - Push below bottom wraps to top silently
// - Pop above top wraps to bottom silently
// - Calls save return address, interrupts save context
// - Push and pop instructions use same rules
// - Interrupt writes return low byte first
// - Call uses two bytes, interrupt five
// - Condition codes pushed, priority set, restored
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_pointer_unit (
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Sequencer command port
  input wire logic cmd_valid,
  input wire stack_pkg::cmd_t cmd,
  input wire logic [7:0] push_data,
  input wire logic [15:0] return_addr,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] x_value,
  input wire logic [1:0] int_priority,
  output logic busy,
  output logic pop_valid,
  output logic [7:0] pop_data,
  output logic [15:0] stack_pointer,
  output logic [7:0] condition_code_reg
);
  // ==========================================================
  // State
  stack_pkg::frame_state_t state;
  stack_pkg::frame_state_t next_state;
  logic [2:0] remain;
  logic [2:0] next_remain;
  logic [39:0] frame;
  logic [39:0] next_frame;
  logic is_int;
  logic next_is_int;
  logic [7:0] cond_code;
  logic [7:0] next_cond_code;
  logic [7:0] next_rdata;
  logic [7:0] next_pop_data;
  logic next_pop_valid;
  logic [7:0] stack_offset_bits;
  logic ptr_dec;
  logic ptr_inc;
  logic ptr_load;
  logic ptr_reset;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_rdata;
  logic pop_phase;

  // ==========================================================
  // Pointer
  // 16-bit pointer view
  assign stack_pointer = {stack_pkg::STACK_PAGE, stack_offset_bits};
  assign condition_code_reg = cond_code;
  assign busy = (state != stack_pkg::ST_IDLE);

  stack_offset_counter u_offset (
    .clk(clk),
    .nrst(nrst),
    .dec(ptr_dec),
    .inc(ptr_inc),
    .load(ptr_load),
    .load_value(wdata),
    .reset_stack(ptr_reset),
    .stack_offset_bits(stack_offset_bits)
  );

  stack_byte_ram u_ram (
    .clk(clk),
    .nrst(nrst),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(frame[7:0]),
    .rdata(ram_rdata)
  );

  // ==========================================================
  // Frame sequencer
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_frame = frame;
    next_is_int = is_int;
    next_cond_code = cond_code;
    next_pop_data = pop_data;
    next_pop_valid = 1'b0;
    ptr_dec = 1'b0;
    ptr_inc = 1'b0;
    ptr_load = 1'b0;
    ptr_reset = 1'b0;
    ram_we = 1'b0;
    pop_phase = 1'b0;
    ram_addr = stack_offset_bits;
    unique case (state)
      stack_pkg::ST_IDLE: begin
        if (wr && (addr == stack_pkg::ADDR_POINTER_LOW)) begin
          ptr_load = 1'b1;
        end
        if (wr && (addr == stack_pkg::ADDR_COND_CODE)) begin
          next_cond_code = wdata;
        end
        if (cmd_valid) begin
          unique case (cmd)
            stack_pkg::CMD_PUSH: begin
              next_frame = {32'h0, push_data};
              next_remain = 3'h1;
              next_state = stack_pkg::ST_PUSHING;
            end
            stack_pkg::CMD_POP: begin
              next_remain = 3'h1;
              next_is_int = 1'b0;
              next_state = stack_pkg::ST_POPPING;
            end
            stack_pkg::CMD_CALL: begin
              next_frame = {24'h0, return_addr[15:8], return_addr[7:0]};
              next_remain = stack_pkg::CALL_BYTES;
              next_state = stack_pkg::ST_PUSHING;
            end
            stack_pkg::CMD_RET: begin
              next_remain = stack_pkg::CALL_BYTES;
              next_is_int = 1'b0;
              next_state = stack_pkg::ST_POPPING;
            end
            stack_pkg::CMD_INT: begin
              next_frame = {cond_code, acc_value, x_value, return_addr[15:8],
                return_addr[7:0]};
              next_remain = stack_pkg::INT_BYTES;
              next_is_int = 1'b1;
              next_state = stack_pkg::ST_PUSHING;
            end
            stack_pkg::CMD_IRET: begin
              next_remain = stack_pkg::INT_BYTES;
              next_is_int = 1'b1;
              next_state = stack_pkg::ST_POPPING;
            end
            stack_pkg::CMD_RESET_STACK: begin
              ptr_reset = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      stack_pkg::ST_PUSHING: begin
        ram_we = 1'b1;
        ptr_dec = 1'b1;
        next_frame = {8'h00, frame[39:8]};
        next_remain = remain - 3'h1;
        if (remain == 3'h1) begin
          next_state = stack_pkg::ST_IDLE;
          if (is_int) begin
            next_cond_code[stack_pkg::PRIO_HIGH_POS] = int_priority[1];
            next_cond_code[stack_pkg::PRIO_LOW_POS] = int_priority[0];
          end
        end
      end
      stack_pkg::ST_POPPING: begin
        pop_phase = 1'b1;
        ptr_inc = 1'b1;
        ram_addr = stack_offset_bits + 8'h01;
        next_pop_data = ram_rdata;
        next_pop_valid = 1'b1;
        next_remain = remain - 3'h1;
        if (is_int && (remain == stack_pkg::INT_BYTES)) begin
          next_cond_code = ram_rdata;
        end
        if (remain == 3'h1) begin
          next_state = stack_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = stack_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= stack_pkg::ST_IDLE;
      remain <= 3'h0;
      frame <= 40'h0;
      is_int <= 1'b0;
      cond_code <= stack_pkg::COND_CODE_RESET;
      pop_data <= 8'h00;
      pop_valid <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      frame <= next_frame;
      is_int <= next_is_int;
      cond_code <= next_cond_code;
      pop_data <= next_pop_data;
      pop_valid <= next_pop_valid;
    end
  end

  // ==========================================================
  // Register read port
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        stack_pkg::ADDR_POINTER_LOW: next_rdata = stack_offset_bits;
        stack_pkg::ADDR_POINTER_HIGH: next_rdata = stack_pkg::STACK_PAGE;
        stack_pkg::ADDR_STATUS: next_rdata = {5'h00, remain};
        stack_pkg::ADDR_COND_CODE: next_rdata = cond_code;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Checks
  property p_page_fixed;
    @(posedge clk) disable iff (!nrst) stack_pointer[15:8] == 8'h01;
  endproperty
  a_page_fixed: assert property (p_page_fixed) else $error("Stack page changed");

  property p_reset_sp;
    @(posedge clk) disable iff (!nrst)
      (state == stack_pkg::ST_IDLE && cmd_valid && cmd == stack_pkg::CMD_RESET_STACK)
      |=> stack_pointer == stack_pkg::POINTER_RESET;
  endproperty
  a_reset_sp: assert property (p_reset_sp) else $error("Stack reset failed");

  property p_push_dec;
    @(posedge clk) disable iff (!nrst)
      state == stack_pkg::ST_PUSHING
      |=> stack_offset_bits == $past(stack_offset_bits) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("Push did not decrement");

  property p_pop_inc;
    @(posedge clk) disable iff (!nrst)
      state == stack_pkg::ST_POPPING
      |=> stack_offset_bits == $past(stack_offset_bits) + 8'h01;
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("Pop did not increment");

  property p_call_len;
    @(posedge clk) disable iff (!nrst)
      (state == stack_pkg::ST_IDLE && cmd_valid && cmd == stack_pkg::CMD_CALL)
      |=> (state == stack_pkg::ST_PUSHING) [*2] ##1 state == stack_pkg::ST_IDLE;
  endproperty
  a_call_len: assert property (p_call_len) else $error("Call frame length wrong");

  property p_int_len;
    @(posedge clk) disable iff (!nrst)
      (state == stack_pkg::ST_IDLE && cmd_valid && cmd == stack_pkg::CMD_INT)
      |=> (state == stack_pkg::ST_PUSHING) [*5] ##1 stack_offset_bits ==
      $past(stack_offset_bits, 6) - 8'h05;
  endproperty
  a_int_len: assert property (p_int_len) else $error("Interrupt frame wrong");

  property p_low_first;
    @(posedge clk) disable iff (!nrst)
      (state == stack_pkg::ST_IDLE && cmd_valid && cmd == stack_pkg::CMD_INT)
      |=> ram_we && ram_addr == $past(stack_offset_bits) && frame[7:0] == $past(return_addr[7:0]);
  endproperty
  a_low_first: assert property (p_low_first) else $error("Return low byte not first");

  property p_load_low;
    @(posedge clk) disable iff (!nrst)
      (state == stack_pkg::ST_IDLE && !cmd_valid && wr && addr == stack_pkg::ADDR_POINTER_LOW)
      |=> stack_offset_bits == $past(wdata);
  endproperty
  a_load_low: assert property (p_load_low) else $error("Low byte load failed");

  property p_high_read;
    @(posedge clk) disable iff (!nrst)
      (rd && addr == stack_pkg::ADDR_POINTER_HIGH) |=> rdata == 8'h01;
  endproperty
  a_high_read: assert property (p_high_read) else $error("Upper byte read wrong");
endmodule : cpu_stack_pointer_unit
`default_nettype wire

// ===== verification/cpu_stack_pointer_unit_test.sv
// Self-checking bench of the stack pointer unit: registers, frames and wrap.
// Assumes the unit alone on one 100 MHz clock; the bench plays sequencer and software.
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_pointer_unit_test;
  // ==========================================================
  // Signals and instance
  logic clk, nrst, wr, rd, cmd_valid, busy, pop_valid;
  logic [1:0] addr, int_priority, pr_v;
  logic [7:0] wdata, rdata, push_data, acc_value, x_value, pop_data, condition_code_reg;
  logic [7:0] d, off, cond_v, a_v, x_v;
  logic [15:0] return_addr, stack_pointer, ra_v;
  stack_pkg::cmd_t cmd;
  logic [31:0] rng;
  logic [7:0] popq[$];
  logic [7:0] pushq[$];
  int n_mismatch, n_checks, n;

  cpu_stack_pointer_unit u_cpu_stack_pointer_unit (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmd_valid(cmd_valid), .cmd(cmd), .push_data(push_data), .return_addr(return_addr),
    .acc_value(acc_value), .x_value(x_value), .int_priority(int_priority), .busy(busy),
    .pop_valid(pop_valid), .pop_data(pop_data), .stack_pointer(stack_pointer),
    .condition_code_reg(condition_code_reg)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Popped bytes land one cycle after each pop step
  always @(posedge clk) begin
    if (pop_valid === 1'b1) popq.push_back(pop_data);
  end

  // ==========================================================
  // Helpers
  function logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd

  function automatic logic [15:0] exp_ptr(input logic [7:0] o);
    return {stack_pkg::STACK_PAGE, o};
  endfunction : exp_ptr

  function automatic logic [7:0] exp_cond(input logic [7:0] c, input logic [1:0] p);
    logic [7:0] e;
    e = c;
    e[stack_pkg::PRIO_HIGH_POS] = p[1];
    e[stack_pkg::PRIO_LOW_POS] = p[0];
    return e;
  endfunction : exp_cond

  // Busy cycles per command equal the bytes moved
  function automatic logic [15:0] exp_len(input stack_pkg::cmd_t c);
    case (c)
      stack_pkg::CMD_PUSH, stack_pkg::CMD_POP: return 16'h0001;
      stack_pkg::CMD_CALL, stack_pkg::CMD_RET: return 16'(stack_pkg::CALL_BYTES);
      stack_pkg::CMD_INT, stack_pkg::CMD_IRET: return 16'(stack_pkg::INT_BYTES);
      default: return 16'h0000;
    endcase
  endfunction : exp_len

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_read

  // Waits are bounded so a stuck busy cannot hang the run
  task automatic run_cmd(input stack_pkg::cmd_t c, input logic [7:0] p);
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    push_data <= p;
    return_addr <= ra_v;
    acc_value <= a_v;
    x_value <= x_v;
    int_priority <= pr_v;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    k = 0;
    while (busy === 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 20) n_mismatch++;
    check(16'(k), exp_len(c));
    @(posedge clk);
    #1;
  endtask : run_cmd

  // ==========================================================
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 2'h0; wdata = 8'h00; cmd_valid = 1'b0;
    cmd = stack_pkg::CMD_NONE; push_data = 8'h00; return_addr = 16'h0000;
    acc_value = 8'h00; x_value = 8'h00; int_priority = 2'h0;
    n_mismatch = 0; n_checks = 0; rng = 32'h00000fa2;
    ra_v = 16'h0000; a_v = 8'h00; x_v = 8'h00; pr_v = 2'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check(stack_pointer, stack_pkg::POINTER_RESET);
    check(condition_code_reg, stack_pkg::COND_CODE_RESET);
    reg_read(stack_pkg::ADDR_POINTER_LOW, d);
    check(d, stack_pkg::STACK_TOP);
    reg_write(stack_pkg::ADDR_POINTER_HIGH, 8'h7e);
    reg_read(stack_pkg::ADDR_POINTER_HIGH, d);
    check(d, stack_pkg::STACK_PAGE);
    check(stack_pointer, stack_pkg::POINTER_RESET);
    reg_read(stack_pkg::ADDR_STATUS, d);
    check(d, 8'h00);
    // First run starts near the bottom so pushes wrap past it
    for (int r = 0; r < 4; r++) begin
      off = (r == 0) ? 8'h02 : rnd();
      n = (r == 0) ? 8 : int'(rnd() & 8'h07) + 1;
      reg_write(stack_pkg::ADDR_POINTER_LOW, off);
      reg_read(stack_pkg::ADDR_POINTER_LOW, d);
      check(d, off);
      for (int k = 0; k < n; k++) begin
        d = rnd();
        pushq.push_back(d);
        run_cmd(stack_pkg::CMD_PUSH, d);
        check(stack_pointer, exp_ptr(off - 8'(k) - 8'h01));
      end
      popq.delete();
      for (int k = 0; k < n; k++) begin
        run_cmd(stack_pkg::CMD_POP, 8'h00);
        check(stack_pointer, exp_ptr(off - 8'(n) + 8'(k) + 8'h01));
      end
      check(16'(popq.size()), 16'(n));
      for (int k = 0; k < n; k++) begin
        check(popq[k], pushq[n - 1 - k]);
      end
      pushq.delete();
    end
    // Call and return across the bottom of the page
    ra_v = {rnd(), rnd()};
    off = 8'h01;
    reg_write(stack_pkg::ADDR_POINTER_LOW, off);
    run_cmd(stack_pkg::CMD_CALL, 8'h00);
    check(stack_pointer, exp_ptr(off - 8'h02));
    popq.delete();
    run_cmd(stack_pkg::CMD_RET, 8'h00);
    check(stack_pointer, exp_ptr(off));
    check({popq[0], popq[1]}, ra_v);
    // Interrupt entry and return with a random context
    cond_v = rnd();
    reg_write(stack_pkg::ADDR_COND_CODE, cond_v);
    check(condition_code_reg, cond_v);
    ra_v = {rnd(), rnd()};
    a_v = rnd();
    x_v = rnd();
    pr_v = 2'(rnd());
    off = rnd();
    reg_write(stack_pkg::ADDR_POINTER_LOW, off);
    run_cmd(stack_pkg::CMD_INT, 8'h00);
    check(stack_pointer, exp_ptr(off - 8'h05));
    check(condition_code_reg, exp_cond(cond_v, pr_v));
    popq.delete();
    run_cmd(stack_pkg::CMD_IRET, 8'h00);
    check(condition_code_reg, cond_v);
    check(stack_pointer, exp_ptr(off));
    check(popq[0], cond_v);
    check(popq[1], a_v);
    check(popq[2], x_v);
    check(popq[3], ra_v[15:8]);
    check(popq[4], ra_v[7:0]);
    // Stack reset command, then a pop past the top wraps
    run_cmd(stack_pkg::CMD_RESET_STACK, 8'h00);
    check(stack_pointer, stack_pkg::POINTER_RESET);
    run_cmd(stack_pkg::CMD_POP, 8'h00);
    check(stack_pointer, exp_ptr(8'h00));
    // Reset inside an interrupt frame; status read while the frame runs
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= stack_pkg::CMD_INT;
    @(posedge clk);
    cmd_valid <= 1'b0;
    rd <= 1'b1;
    addr <= stack_pkg::ADDR_STATUS;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, 16'(stack_pkg::INT_BYTES));
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    check(stack_pointer, stack_pkg::POINTER_RESET);
    check(condition_code_reg, stack_pkg::COND_CODE_RESET);
    check(busy, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    // Unit must work again right after release
    run_cmd(stack_pkg::CMD_PUSH, rnd());
    check(stack_pointer, exp_ptr(8'hfe));
    finish_test();
  end
endmodule : cpu_stack_pointer_unit_test
`default_nettype wire
